// [pkg/mmdd_pkg.sv]
// Field layout, mode codes and address constants of the message data word
`default_nettype none
package mmdd_pkg;
  // Message data word layout
  localparam int MMDD_DATA_W = 16;
  localparam int MMDD_VEC_LSB = 0;
  localparam int MMDD_VEC_W = 8;
  localparam int MMDD_MODE_LSB = 8;
  localparam int MMDD_MODE_W = 3;
  localparam int MMDD_LEVEL_BIT = 14;
  localparam int MMDD_TRIG_BIT = 15;
  localparam logic [MMDD_DATA_W-1:0] MMDD_DATA_RST = 16'h0000;
  // Legal vector range
  localparam logic [MMDD_VEC_W-1:0] MMDD_VEC_MIN = 8'h10;
  localparam logic [MMDD_VEC_W-1:0] MMDD_VEC_MAX = 8'hfe;
  localparam logic [MMDD_VEC_W-1:0] MMDD_VEC_ZERO = 8'h00;
  // Delivery mode codes
  localparam logic [MMDD_MODE_W-1:0] MMDD_MODE_FIXED = 3'h0;
  localparam logic [MMDD_MODE_W-1:0] MMDD_MODE_LOWEST = 3'h1;
  localparam logic [MMDD_MODE_W-1:0] MMDD_MODE_SYS_MGMT = 3'h2;
  localparam logic [MMDD_MODE_W-1:0] MMDD_MODE_NON_MASK = 3'h4;
  localparam logic [MMDD_MODE_W-1:0] MMDD_MODE_RESTART = 3'h5;
  localparam logic [MMDD_MODE_W-1:0] MMDD_MODE_EXT_CTRL = 3'h7;
  // Trigger mode bit values
  localparam logic MMDD_TRIG_EDGE = 1'h0;
  localparam logic MMDD_TRIG_LEVEL = 1'h1;
  localparam logic MMDD_LEVEL_ASSERT = 1'h1;
  // Message address layout
  localparam int MMDD_ADDR_W = 32;
  localparam int MMDD_PREFIX_LSB = 20;
  localparam int MMDD_PREFIX_W = 12;
  localparam logic [MMDD_PREFIX_W-1:0] MMDD_ADDR_PREFIX = 12'hfee;
  localparam int MMDD_DEST_LSB = 12;
  localparam int MMDD_DEST_W = 8;
  localparam logic [MMDD_DEST_W-1:0] MMDD_DEST_RST = 8'h00;
  // Full DWORD byte enables
  localparam logic [3:0] MMDD_BE_DWORD = 4'hf;
  // Sender states, one-hot
  typedef enum logic [1:0] {
    MMDD_ST_IDLE = 2'b01,
    MMDD_ST_SEND = 2'b10
  } mmdd_state_type;
endpackage
`default_nettype wire

// [src/mmdd_field_decode.sv]
// Combinational decode of one message data word into its meaning
`timescale 1ns/100ps
`default_nettype none
module mmdd_field_decode
  import mmdd_pkg::*;
(
  // Word under decode
  input wire logic [MMDD_DATA_W-1:0] word_i,
  // Decoded meaning
  output logic [MMDD_VEC_W-1:0] vector_o,
  output logic [MMDD_MODE_W-1:0] mode_o,
  output logic edge_o,
  output logic assert_o,
  output logic vec_used_o,
  output logic lowest_o,
  output logic ack_cycle_o,
  output logic word_ok_o
);
  // Raw fields
  wire logic [MMDD_VEC_W-1:0] vec_raw = word_i[MMDD_VEC_LSB +: MMDD_VEC_W];
  wire logic [MMDD_MODE_W-1:0] mode_raw =
    word_i[MMDD_MODE_LSB +: MMDD_MODE_W];
  wire logic trig_raw = word_i[MMDD_TRIG_BIT];
  wire logic level_raw = word_i[MMDD_LEVEL_BIT];
  // Mode classes
  wire logic is_fixed = (mode_raw == MMDD_MODE_FIXED); // RULE_04
  wire logic is_lowest = (mode_raw == MMDD_MODE_LOWEST); // RULE_05
  wire logic is_smi = (mode_raw == MMDD_MODE_SYS_MGMT); // RULE_06
  wire logic is_nmi = (mode_raw == MMDD_MODE_NON_MASK); // RULE_07
  wire logic is_rst = (mode_raw == MMDD_MODE_RESTART); // RULE_08
  wire logic is_ext = (mode_raw == MMDD_MODE_EXT_CTRL); // RULE_09
  wire logic mode_known = is_fixed | is_lowest | is_smi | is_nmi |
    is_rst | is_ext;
  // Fixed, lowest priority and the unassigned codes 3 and 6 honour the trigger bit
  wire logic forced_edge = is_smi | is_nmi | is_rst | is_ext;
  wire logic edge_eff = forced_edge | (trig_raw == MMDD_TRIG_EDGE); // RULE_12
  wire logic vec_in_range = (vec_raw >= MMDD_VEC_MIN) &&
    (vec_raw <= MMDD_VEC_MAX); // RULE_01
  // Vector carries meaning only for fixed and lowest priority
  wire logic vec_used = is_fixed | is_lowest;
  // System management must carry an all-zero vector
  wire logic smi_vec_ok = ~is_smi | (vec_raw == MMDD_VEC_ZERO); // RULE_06
  wire logic vec_ok = ~vec_used | vec_in_range; // RULE_02
  assign vector_o = vec_used ? vec_raw : MMDD_VEC_ZERO;
  assign mode_o = mode_raw;
  assign edge_o = edge_eff; // RULE_07 RULE_08
  // Edge messages always assert; level messages carry the line
  assign assert_o = edge_eff ? MMDD_LEVEL_ASSERT : level_raw; // RULE_10
  assign vec_used_o = vec_used;
  assign lowest_o = is_lowest;
  assign ack_cycle_o = is_ext; // RULE_09
  assign word_ok_o = mode_known & vec_ok & smi_vec_ok; // RULE_03
endmodule
`default_nettype wire

// [src/mmdd_core.sv]
// Message-signalled interrupt data word sender and receiver decode
//
// Summary of operation
// RULE_01 - Vector is 8 bits, legal 10h to FEh
// RULE_02 - Configuring party never programs vectors 00h-0Fh
// RULE_03 - Delivery mode 3 bits, trigger must match
// RULE_04 - Mode 000 fixed, all agents, edge/level
// RULE_05 - Mode 001 lowest priority agent, edge/level
// RULE_06 - Mode 010 system management, edge, zero vector
// RULE_07 - Mode 100 non-maskable, vector ignored, edge
// RULE_08 - Mode 101 restart, vector ignored, edge
// RULE_09 - Mode 111 external controller, acknowledge supplies vector
// RULE_10 - Edge messages always mean assertion
// RULE_11 - Level messages carry current input state
// RULE_12 - Trigger bit 0 edge, 1 level
// RULE_13 - Writers preserve reserved bits of word
// RULE_14 - Address bits 31:20 hold fixed prefix
// RULE_15 - Peripheral sends one DWORD write to address
// RULE_16 - Address holds 8-bit destination identifier
// RULE_17 - Vector 7:0, mode 10:8, level 14, trigger 15
`timescale 1ns/100ps
`default_nettype none
module mmdd_core
  import mmdd_pkg::*;
#(
  parameter int DATA_W = MMDD_DATA_W,
  parameter int ADDR_W = MMDD_ADDR_W
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Configuration writes and readback
  input wire logic cfg_data_wr_i,
  input wire logic cfg_dest_wr_i,
  input wire logic [DATA_W-1:0] cfg_wdata_i,
  input wire logic msg_en_i,
  output logic [DATA_W-1:0] cfg_data_o,
  output logic [MMDD_DEST_W-1:0] cfg_dest_o,
  output logic cfg_err_o,
  // Originating interrupt input
  input wire logic irq_i,
  // Outgoing DWORD memory write
  output logic wr_valid_o,
  output logic [ADDR_W-1:0] wr_addr_o,
  output logic [ADDR_W-1:0] wr_data_o,
  input wire logic wr_ready_i,
  // Incoming memory write to decode
  input wire logic rx_valid_i,
  input wire logic [ADDR_W-1:0] rx_addr_i,
  input wire logic [ADDR_W-1:0] rx_data_i,
  input wire logic [3:0] rx_be_i,
  // Decoded incoming message
  output logic rx_hit_o,
  output logic rx_bad_o,
  output logic [MMDD_DEST_W-1:0] rx_dest_o,
  output logic [MMDD_VEC_W-1:0] rx_vector_o,
  output logic [MMDD_MODE_W-1:0] rx_mode_o,
  output logic rx_edge_o,
  output logic rx_assert_o,
  output logic rx_lowest_o,
  output logic rx_ack_cycle_o
);
  // Refuse widths the fixed field layout cannot serve
  if (DATA_W != MMDD_DATA_W) begin : g_bad_data_w
    $error("mmdd_core: DATA_W must equal the word width");
  end
  if (ADDR_W != MMDD_ADDR_W) begin : g_bad_addr_w
    $error("mmdd_core: ADDR_W must be 32");
  end

  // Stored registers
  logic [DATA_W-1:0] data_q; // Message data word, reserved bits kept
  logic [MMDD_DEST_W-1:0] dest_q; // Destination identifier
  logic cfg_err_q; // Configured word is unusable
  logic irq_q; // Previous interrupt input
  logic pend_q; // Event waiting to be sent
  logic pend_d;
  mmdd_state_type state_q;
  mmdd_state_type state_d;
  logic wr_valid_q;
  logic [ADDR_W-1:0] wr_addr_q;
  logic [ADDR_W-1:0] wr_data_q;

  // Decode of the configured word, only what the sender needs
  logic [MMDD_VEC_W-1:0] cfg_vec;
  logic cfg_edge;
  logic cfg_vec_used;
  logic cfg_ok;

  mmdd_field_decode u_cfg_dec (
    .word_i(data_q),
    .vector_o(cfg_vec),
    .mode_o(),
    .edge_o(cfg_edge),
    .assert_o(),
    .vec_used_o(cfg_vec_used),
    .lowest_o(),
    .ack_cycle_o(),
    .word_ok_o(cfg_ok)
  );

  // Interrupt input events
  wire logic irq_rise = irq_i & ~irq_q;
  wire logic irq_change = irq_i ^ irq_q;
  // Edge modes send on rising input, level modes on every change
  wire logic evt = msg_en_i & cfg_ok &
    (cfg_edge ? irq_rise : irq_change); // RULE_11 RULE_12
  wire logic idle = (state_q == MMDD_ST_IDLE);
  wire logic launch = idle & (pend_q | evt);
  wire logic done = (state_q == MMDD_ST_SEND) & wr_ready_i;

  // Level bit: assert for edge, present input state for level
  wire logic tx_level = cfg_edge ? MMDD_LEVEL_ASSERT : irq_i; // RULE_10 RULE_11
  // Word to send: vector zeroed where it is ignored, level patched
  wire logic [DATA_W-1:0] tx_word = {
    data_q[MMDD_TRIG_BIT],
    tx_level,
    data_q[MMDD_LEVEL_BIT-1:MMDD_MODE_LSB],
    cfg_vec}; // RULE_06 RULE_17
  // Target address: fixed prefix plus destination
  wire logic [ADDR_W-1:0] tx_addr = {
    MMDD_ADDR_PREFIX,
    dest_q,
    {MMDD_DEST_LSB{1'b0}}}; // RULE_14 RULE_16

  // Pending event: the clear on launch wins, so an event in a launch cycle is served by that launch and not kept
  always_comb begin
    pend_d = pend_q;
    if (launch) begin
      pend_d = 1'b0;
    end
    if (evt && !launch) begin
      pend_d = 1'b1;
    end
  end

  // Sender sequence
  always_comb begin
    state_d = state_q;
    unique case (state_q)
      MMDD_ST_IDLE: begin
        if (launch) begin
          state_d = MMDD_ST_SEND;
        end
      end
      MMDD_ST_SEND: begin
        if (wr_ready_i) begin
          state_d = MMDD_ST_IDLE;
        end
      end
    endcase
  end

  // Configuration registers, whole word stored so reserved bits survive
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      data_q <= MMDD_DATA_RST;
      dest_q <= MMDD_DEST_RST;
      cfg_err_q <= 1'b0;
    end else begin
      if (cfg_data_wr_i) begin
        data_q <= cfg_wdata_i; // RULE_13
      end
      if (cfg_dest_wr_i) begin
        dest_q <= cfg_wdata_i[MMDD_DEST_W-1:0]; // RULE_16
      end
      cfg_err_q <= ~cfg_ok; // RULE_03
    end
  end

  // Sender state and write outputs
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      state_q <= MMDD_ST_IDLE;
      irq_q <= 1'b0;
      pend_q <= 1'b0;
      wr_valid_q <= 1'b0;
      wr_addr_q <= '0;
      wr_data_q <= '0;
    end else begin
      state_q <= state_d;
      irq_q <= irq_i;
      pend_q <= pend_d;
      if (launch) begin
        wr_valid_q <= 1'b1; // RULE_15
        wr_addr_q <= tx_addr;
        wr_data_q <= {{(ADDR_W-DATA_W){1'b0}}, tx_word};
      end else if (done) begin
        wr_valid_q <= 1'b0;
      end
    end
  end

  // Receive side decode
  logic [MMDD_VEC_W-1:0] rx_vec;
  logic [MMDD_MODE_W-1:0] rx_mode;
  logic rx_edge;
  logic rx_assert;
  logic rx_lowest;
  logic rx_ack;
  logic rx_ok;

  mmdd_field_decode u_rx_dec (
    .word_i(rx_data_i[DATA_W-1:0]),
    .vector_o(rx_vec),
    .mode_o(rx_mode),
    .edge_o(rx_edge),
    .assert_o(rx_assert),
    .vec_used_o(),
    .lowest_o(rx_lowest),
    .ack_cycle_o(rx_ack),
    .word_ok_o(rx_ok)
  );

  // A write is a message when it lands in the prefix region
  wire logic rx_prefix = (rx_addr_i[MMDD_PREFIX_LSB +: MMDD_PREFIX_W] ==
    MMDD_ADDR_PREFIX); // RULE_14
  wire logic rx_hit = rx_valid_i & rx_prefix;
  // Partial writes and illegal words are flagged on rx_bad_o but still decoded and delivered
  wire logic rx_bad = ~rx_ok | (rx_be_i != MMDD_BE_DWORD); // RULE_02 RULE_15

  // Receive outputs, one-cycle pulse with held fields
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i) begin
      rx_hit_o <= 1'b0;
      rx_bad_o <= 1'b0;
      rx_dest_o <= MMDD_DEST_RST;
      rx_vector_o <= MMDD_VEC_ZERO;
      rx_mode_o <= MMDD_MODE_FIXED;
      rx_edge_o <= 1'b0;
      rx_assert_o <= 1'b0;
      rx_lowest_o <= 1'b0;
      rx_ack_cycle_o <= 1'b0;
    end else begin
      rx_hit_o <= rx_hit;
      rx_bad_o <= rx_hit & rx_bad;
      if (rx_hit) begin
        rx_dest_o <= rx_addr_i[MMDD_DEST_LSB +: MMDD_DEST_W]; // RULE_16
        rx_vector_o <= rx_vec; // RULE_01 RULE_07 RULE_08
        rx_mode_o <= rx_mode; // RULE_04
        rx_edge_o <= rx_edge; // RULE_12
        rx_assert_o <= rx_assert; // RULE_10 RULE_11
        rx_lowest_o <= rx_lowest; // RULE_05
        rx_ack_cycle_o <= rx_ack; // RULE_09
      end
    end
  end

  // Output drivers
  assign cfg_data_o = data_q;
  assign cfg_dest_o = dest_q;
  assign cfg_err_o = cfg_err_q;
  assign wr_valid_o = wr_valid_q;
  assign wr_addr_o = wr_addr_q;
  assign wr_data_o = wr_data_q;

  // Checks
  default clocking cb @(posedge clk_sys_i); endclocking
  default disable iff (sys_rst_i);

  sequence s_level_change;
    idle && !pend_q && msg_en_i && cfg_ok && !cfg_edge &&
      (irq_i != irq_q);
  endsequence
  sequence s_rx_mode(logic [MMDD_MODE_W-1:0] m);
    rx_hit_o && !rx_bad_o && rx_mode_o == m;
  endsequence

  property p_tx_prefix;
    wr_valid_o |->
      wr_addr_o[MMDD_PREFIX_LSB +: MMDD_PREFIX_W] == MMDD_ADDR_PREFIX;
  endproperty
  a_tx_prefix: assert property (p_tx_prefix) // RULE_14
    else $error("message address prefix wrong");

  property p_tx_dest;
    $rose(wr_valid_o) |-> wr_addr_o[MMDD_DEST_LSB +: MMDD_DEST_W] ==
      $past(dest_q);
  endproperty
  a_tx_dest: assert property (p_tx_dest) // RULE_16
    else $error("destination not placed in address");

  property p_tx_vec;
    $rose(wr_valid_o) && $past(cfg_vec_used) |->
      wr_data_o[MMDD_VEC_LSB +: MMDD_VEC_W] >= MMDD_VEC_MIN &&
      wr_data_o[MMDD_VEC_LSB +: MMDD_VEC_W] <= MMDD_VEC_MAX;
  endproperty
  a_tx_vec: assert property (p_tx_vec) // RULE_01
    else $error("illegal vector sent");

  property p_tx_level;
    s_level_change |=> wr_valid_o && wr_data_o[MMDD_LEVEL_BIT] == $past(irq_i);
  endproperty
  a_tx_level: assert property (p_tx_level) // RULE_11
    else $error("level message missing or wrong level");

  property p_tx_smi;
    wr_valid_o &&
      wr_data_o[MMDD_MODE_LSB +: MMDD_MODE_W] == MMDD_MODE_SYS_MGMT |->
      wr_data_o[MMDD_VEC_LSB +: MMDD_VEC_W] == MMDD_VEC_ZERO &&
      wr_data_o[MMDD_LEVEL_BIT];
  endproperty
  a_tx_smi: assert property (p_tx_smi) // RULE_06
    else $error("system management message malformed");

  property p_tx_hold;
    wr_valid_o && !wr_ready_i |=> wr_valid_o && $stable(wr_data_o);
  endproperty
  a_tx_hold: assert property (p_tx_hold) // RULE_15
    else $error("write dropped before acceptance");

  property p_rx_nmi;
    s_rx_mode(MMDD_MODE_NON_MASK) |-> rx_edge_o && rx_assert_o &&
      rx_vector_o == MMDD_VEC_ZERO;
  endproperty
  a_rx_nmi: assert property (p_rx_nmi) // RULE_07
    else $error("non-maskable not edge or vector kept");

  property p_rx_restart;
    s_rx_mode(MMDD_MODE_RESTART) |-> rx_edge_o && rx_assert_o;
  endproperty
  a_rx_restart: assert property (p_rx_restart) // RULE_08
    else $error("restart not treated as edge");

  property p_rx_ext;
    s_rx_mode(MMDD_MODE_EXT_CTRL) |-> rx_ack_cycle_o && rx_edge_o;
  endproperty
  a_rx_ext: assert property (p_rx_ext) // RULE_09
    else $error("external controller message lacks acknowledge");

  property p_rx_trig;
    s_rx_mode(MMDD_MODE_FIXED) |->
      rx_edge_o == !$past(rx_data_i[MMDD_TRIG_BIT]);
  endproperty
  a_rx_trig: assert property (p_rx_trig) // RULE_12
    else $error("trigger bit decoded wrongly");
endmodule
`default_nettype wire

// [dv/mmdd_far_model.sv]
// Far-side bus model that accepts outgoing message writes after a stall
`timescale 1ns/100ps
`default_nettype none
module mmdd_far_model (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic sys_rst_i,
  // Outgoing write and chosen stall length
  input wire logic wr_valid_i,
  input wire logic [3:0] stall_i,
  // Acceptance of the write
  output logic wr_ready_o
);
  // Cycles the current write has waited
  logic [3:0] wait_q;
  // Take one whole DWORD write once the stall has run out
  assign wr_ready_o = wr_valid_i && (wait_q >= stall_i);
  // Count waiting cycles, cleared on acceptance
  always_ff @(posedge clk_sys_i) begin
    if (sys_rst_i || wr_ready_o) begin
      wait_q <= 4'h0;
    end else if (wr_valid_i && wait_q != 4'hf) begin
      wait_q <= wait_q + 4'h1;
    end
  end
endmodule
`default_nettype wire

// [dv/test_msi_message_data_decode.sv]
// Self-checking bench for the message data word sender and decoder
`timescale 1ns/100ps
`default_nettype none
module test_msi_message_data_decode;
  import mmdd_pkg::*;
  // Clock, reset and design inputs
  logic clk_sys_i = 1'h0;
  logic sys_rst_i = 1'h1;
  logic cfg_data_wr_i = 1'h0;
  logic cfg_dest_wr_i = 1'h0;
  logic [15:0] cfg_wdata_i = 16'h0000;
  logic msg_en_i = 1'h0;
  logic irq_i = 1'h0;
  logic rx_valid_i = 1'h0;
  logic [31:0] rx_addr_i = 32'h0;
  logic [31:0] rx_data_i = 32'h0;
  logic [3:0] rx_be_i = 4'h0;
  logic [3:0] stall = 4'h0;
  // Design outputs
  logic [15:0] cfg_data_o;
  logic [7:0] cfg_dest_o, rx_dest_o, rx_vector_o;
  logic [31:0] wr_addr_o, wr_data_o;
  logic [2:0] rx_mode_o;
  logic cfg_err_o, wr_valid_o, wr_ready_i, rx_hit_o, rx_bad_o;
  logic rx_edge_o, rx_assert_o, rx_lowest_o, rx_ack_cycle_o;
  // Bench state and expectation queues
  int failures = 0;
  int n_tests = 0;
  logic [31:0] seed = 32'h2647eaec;
  logic [31:0] exp_addr = 32'h0;
  logic [63:0] wr_q[$];
  logic [23:0] rx_q[$];
  logic [2:0] modes [6] = '{MMDD_MODE_FIXED, MMDD_MODE_LOWEST,
    MMDD_MODE_SYS_MGMT, MMDD_MODE_NON_MASK, MMDD_MODE_RESTART,
    MMDD_MODE_EXT_CTRL};
  logic [15:0] bad_w [5] = '{16'h000f, 16'h01ff, 16'h0201, 16'h0310,
    16'h0610};
  mmdd_core i_mmdd_core (.clk_sys_i, .sys_rst_i, .cfg_data_wr_i,
    .cfg_dest_wr_i, .cfg_wdata_i, .msg_en_i, .cfg_data_o, .cfg_dest_o,
    .cfg_err_o, .irq_i, .wr_valid_o, .wr_addr_o, .wr_data_o, .wr_ready_i,
    .rx_valid_i, .rx_addr_i, .rx_data_i, .rx_be_i, .rx_hit_o, .rx_bad_o,
    .rx_dest_o, .rx_vector_o, .rx_mode_o, .rx_edge_o, .rx_assert_o,
    .rx_lowest_o, .rx_ack_cycle_o);
  mmdd_far_model i_mmdd_far_model (.clk_sys_i, .sys_rst_i,
    .wr_valid_i(wr_valid_o), .stall_i(stall), .wr_ready_o(wr_ready_i));
  // Free-running 100 ns clock
  initial begin
    forever #50 clk_sys_i = ~clk_sys_i;
  end
  // Fixed-seed xorshift source
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // Compare and count
  task automatic chk(input string name, input logic [63:0] seen,
                     input logic [63:0] exp);
    n_tests++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Verdict and end of run
  task automatic close_out();
    $display("checks %0d failures %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic tick(input int n);
    repeat (n) @(negedge clk_sys_i);
  endtask
  // Store data word then destination id
  task automatic cfg(input logic [15:0] w, input logic [7:0] d);
    cfg_data_wr_i = 1'h1;
    cfg_wdata_i = w;
    tick(1);
    cfg_data_wr_i = 1'h0;
    cfg_dest_wr_i = 1'h1;
    cfg_wdata_i = {8'h00, d};
    exp_addr = {MMDD_ADDR_PREFIX, d, 12'h000};
    tick(1);
    cfg_dest_wr_i = 1'h0;
    tick(3);
  endtask
  // Bounded wait until every noted write was seen
  task automatic drain();
    for (int i = 0; i < 60 && wr_q.size() > 0; i++) tick(1);
    if (wr_q.size() > 0) begin
      failures++;
      close_out();
    end
    tick(2);
  endtask
  // Set irq_i and note the write it should launch
  task automatic irq(input logic v, input logic send, input logic [15:0] w);
    irq_i = v;
    if (send) wr_q.push_back({exp_addr, 16'h0000, w});
    tick(1);
  endtask
  // Present one incoming write and note the decode
  task automatic rx(input logic [31:0] a, input logic [15:0] w,
                    input logic [3:0] be);
    logic [2:0] m;
    logic fl, edg, bad, unk;
    m = w[10:8];
    fl = (m == MMDD_MODE_FIXED) || (m == MMDD_MODE_LOWEST);
    // Unassigned codes keep the trigger bit and are always flagged
    unk = (m == 3'h3) || (m == 3'h6);
    edg = (!fl && !unk) || !w[15];
    bad = be != 4'hf || unk ||
      (fl && (w[7:0] < 8'h10 || w[7:0] == 8'hff)) ||
      (m == MMDD_MODE_SYS_MGMT && w[7:0] != 8'h00);
    rx_valid_i = 1'h1;
    rx_addr_i = a;
    rx_data_i = {16'h0000, w};
    rx_be_i = be;
    if (a[31:20] == MMDD_ADDR_PREFIX) rx_q.push_back({a[19:12],
      fl ? w[7:0] : 8'h00, m, edg, edg | w[14], m == MMDD_MODE_LOWEST,
      m == MMDD_MODE_EXT_CTRL, bad});
    tick(1);
  endtask
  // Watch accepted writes and decode pulses against the notes
  always @(posedge clk_sys_i) begin
    if (!sys_rst_i && wr_valid_o && wr_ready_i) begin
      if (wr_q.size() == 0) chk("spare write", 1, 0);
      else chk("write", {wr_addr_o, wr_data_o}, wr_q.pop_front());
    end
    if (!sys_rst_i && rx_hit_o) begin
      if (rx_q.size() == 0) chk("spare hit", 1, 0);
      else chk("decode", {rx_dest_o, rx_vector_o, rx_mode_o,
        rx_edge_o, rx_assert_o, rx_lowest_o, rx_ack_cycle_o, rx_bad_o},
        rx_q.pop_front());
    end
  end
  // Main sequence
  initial begin
    logic [31:0] r;
    logic [15:0] w;
    logic [7:0] v;
    logic t, fl;
    tick(3);
    sys_rst_i = 1'h0;
    tick(2);
    chk("reset word", cfg_data_o, 16'h0000);
    chk("reset err", cfg_err_o, 1'h1);
    msg_en_i = 1'h1;
    // Every legal mode, prompt then stalling far side
    for (int k = 0; k < 12; k++) begin
      r = rnd();
      fl = modes[k % 6] == MMDD_MODE_FIXED ||
        modes[k % 6] == MMDD_MODE_LOWEST;
      v = k == 0 ? 8'h10 : k == 1 ? 8'hfe : 8'(32'h10 + r % 32'd239);
      v = fl ? v : 8'h00;
      t = fl & (r[0] | k == 1);
      stall = k >= 6 ? {1'h0, r[18:16]} : 4'h0;
      w = {t, 4'h0, modes[k % 6], v};
      cfg(w, r[15:8]);
      chk("cfg err", cfg_err_o, 1'h0);
      chk("dest", cfg_dest_o, r[15:8]);
      irq(1'h1, 1'h1, {t, 1'h1, w[13:0]});
      drain();
      irq(1'h0, t, {t, 1'h0, w[13:0]});
      drain();
    end
    // Second rise while the first write stalls is kept pending
    stall = 4'h6;
    cfg(16'h0042, 8'h5a);
    irq(1'h1, 1'h1, 16'h4042);
    irq(1'h0, 1'h0, 16'h0000);
    irq(1'h1, 1'h1, 16'h4042);
    drain();
    irq(1'h0, 1'h0, 16'h0000);
    // Unusable words raise the flag and send nothing
    stall = 4'h0;
    foreach (bad_w[i]) begin
      cfg(bad_w[i], 8'h11);
      chk("bad cfg", cfg_err_o, 1'h1);
      irq(1'h1, 1'h0, 16'h0000);
      irq(1'h0, 1'h0, 16'h0000);
    end
    // Disabled sending, then reserved bits read back intact
    cfg(16'h0042, 8'h22);
    msg_en_i = 1'h0;
    irq(1'h1, 1'h0, 16'h0000);
    irq(1'h0, 1'h0, 16'h0000);
    cfg(16'h3ae5, 8'hc3);
    chk("readback", cfg_data_o, 16'h3ae5);
    // Back-to-back incoming writes, last one outside the prefix
    for (int k = 0; k < 16; k++) begin
      r = rnd();
      rx({k == 15 ? 12'hfed : MMDD_ADDR_PREFIX, r[27:20], 12'h000},
        {r[15:14], 3'h0, k == 13 ? 3'h6 : modes[k % 6], r[7:0]},
        k < 12 ? MMDD_BE_DWORD : r[19:16]);
    end
    rx_valid_i = 1'h0;
    tick(3);
    chk("decode left", rx_q.size(), 0);
    close_out();
  end
endmodule
`default_nettype wire
